// [inc/status_bank_pkg.sv]
// Purpose: Shared constants and carriers for the latched status register bank.
// Assumes: One 125 MHz clock; the framer logic feeding the bank shares that clock.
// Notes: Register addresses are on the 8-bit parallel control port.
package status_bank_pkg;
   // ----------------------------------------
   // Register addresses and bank indices
   // ----------------------------------------
   localparam logic [7:0] ADDR_STATUS_ONE = 8'h20;
   localparam logic [7:0] ADDR_STATUS_TWO = 8'h21;
   localparam logic [7:0] ADDR_INFO_ONE = 8'h22;
   localparam logic [7:0] ADDR_INFO_TWO = 8'h31;
   localparam logic [7:0] ADDR_INFO_THREE = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK_ONE = 8'h16;
   localparam logic [7:0] ADDR_IRQ_MASK_TWO = 8'h17;
   localparam int NUM_REGS = 5;
   localparam logic [2:0] IDX_STAT_ONE = 3'h0;
   localparam logic [2:0] IDX_STAT_TWO = 3'h1;
   localparam logic [2:0] IDX_INFO_ONE = 3'h2;
   localparam logic [2:0] IDX_INFO_TWO = 3'h3;
   localparam logic [2:0] IDX_INFO_THREE = 3'h4;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int ALARM_BITS = 4;
   localparam int POS_SYNC_LOSS = 0;
   localparam int POS_CARRIER_LOSS = 1;
   localparam int POS_BLUE = 3;
   localparam int POS_SEVERE = 2;
   localparam int POS_SIXTEEN_ZERO = 5;
   localparam int POS_FBIT_ERR = 0;
   localparam int POS_CARRIER_RESTORED = 6;
   // ----------------------------------------
   // Detector constants
   // ----------------------------------------
   localparam logic [4:0] ZERO_SHORT = 5'h08;
   localparam logic [4:0] ZERO_LONG = 5'h10;
   localparam int FBIT_WINDOW = 6;
   localparam int FBIT_LIMIT = 2;
   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } host_req_s;
   typedef struct packed {
      logic [3:0] stat_one_event;
      logic [3:0] alarm_level;
      logic [7:0] stat_two_event;
      logic align_chg;
      logic rx_store_full;
      logic rx_store_empty;
      logic b8zs_seen;
      logic fbit_strobe;
      logic fbit_err;
      logic rx_bit_valid;
      logic rx_bit;
      logic tx_store_full;
      logic tx_store_empty;
      logic tx_slip;
      logic rx_density;
      logic tx_density;
      logic [7:0] info_three_event;
   } framer_evt_s;
endpackage

// [src/latched_status_irq_bank.sv]
// Purpose: Latched status and receive information registers with interrupt output.
// Assumes: Host accesses are one-cycle strobes; framer events are clock-synchronous.
// Notes: Reads answer one cycle after the strobe on rdata_o.
// Functional notes
// - An event or present condition sets its bit, which stays latched until read.
// - A read clears latched bits armed by the last mask write, but alarm bits stay set while the alarm lasts.
// - A mask write refreshes readable bits written 1 and holds bits written 0.
// - Only the two status registers and the facility link status drive the interrupt.
// - Alarm bits pull the interrupt low on every change of alarm state.
// - An alarm interrupt is released by reading its bit, even if the alarm remains.
// - Event bits pull the interrupt low until the causing bit is read.
// - Info register one bit 7 flags a change of alignment after resync.
// - Bits 6 and 5 flag zero strings of at least eight and sixteen.
// - Bits 4 and 3 flag receive store full and empty slips.
// - Info register two flags carrier restored and holds it until read.
// - Info register two flags transmit store full and empty separately.
// - Info register two bits 1 and 0 flag receive and transmit density violations.
module latched_status_irq_bank (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Parallel control port
   input status_bank_pkg::host_req_s host_i,
   output logic [7:0] rdata_o,
   // Framer events and facility link interrupt request
   input status_bank_pkg::framer_evt_s evt_i,
   input wire logic fdl_irq_i,
   // Interrupt
   output logic irq_n_o
);
   import status_bank_pkg::*;

   logic [7:0] latch [NUM_REGS];
   logic [7:0] copy [NUM_REGS];
   logic [7:0] armed [NUM_REGS];
   logic [7:0] set_v [NUM_REGS];
   logic [7:0] clr_v [NUM_REGS];
   logic [7:0] irq_mask_one;
   logic [7:0] irq_mask_two;
   logic [3:0] alarm_q;
   logic [3:0] alarm_chg;
   logic [3:0] alarm_fall;
   logic [3:0] alarm_pend;
   logic [4:0] zero_cnt;
   logic [FBIT_WINDOW-1:0] fbit_hist;
   logic zero8_p;
   logic zero16_p;
   logic severe_p;
   logic hit;
   logic [2:0] idx;
   logic any_src;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   always_comb begin
      hit = 1'b1;
      idx = IDX_STAT_ONE;
      unique case (host_i.addr)
         ADDR_STATUS_ONE: idx = IDX_STAT_ONE;
         ADDR_STATUS_TWO: idx = IDX_STAT_TWO;
         ADDR_INFO_ONE: idx = IDX_INFO_ONE;
         ADDR_INFO_TWO: idx = IDX_INFO_TWO;
         ADDR_INFO_THREE: idx = IDX_INFO_THREE;
         default: hit = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Event detectors
   // ----------------------------------------
   assign alarm_chg = evt_i.alarm_level ^ alarm_q;
   assign alarm_fall = alarm_q & ~evt_i.alarm_level;
   assign zero8_p = evt_i.rx_bit_valid && !evt_i.rx_bit && zero_cnt == ZERO_SHORT - 5'h01;
   assign zero16_p = evt_i.rx_bit_valid && !evt_i.rx_bit && zero_cnt == ZERO_LONG - 5'h01;
   // The window counts the newest framing bit together with the five before it.
   assign severe_p = evt_i.fbit_strobe && evt_i.fbit_err &&
      ($countones(fbit_hist[FBIT_WINDOW-2:0]) >= FBIT_LIMIT - 1);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alarm_q <= 4'h0;
      end else begin
         alarm_q <= evt_i.alarm_level;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         zero_cnt <= 5'h00;
      end else if (evt_i.rx_bit_valid) begin
         // Saturates so that long strings neither wrap nor flag twice.
         if (evt_i.rx_bit) begin
            zero_cnt <= 5'h00;
         end else if (zero_cnt != ZERO_LONG) begin
            zero_cnt <= zero_cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fbit_hist <= '0;
      end else if (evt_i.fbit_strobe) begin
         fbit_hist <= {fbit_hist[FBIT_WINDOW-2:0], evt_i.fbit_err};
      end
   end

   // ----------------------------------------
   // Set and clear vectors
   // ----------------------------------------
   always_comb begin
      // Alarm levels are set terms every cycle, so a read cannot clear a live alarm.
      set_v[IDX_STAT_ONE] = {evt_i.stat_one_event, evt_i.alarm_level};
      set_v[IDX_STAT_TWO] = evt_i.stat_two_event;
      set_v[IDX_INFO_ONE] = {evt_i.align_chg, zero8_p, zero16_p, evt_i.rx_store_full,
         evt_i.rx_store_empty, severe_p, evt_i.b8zs_seen,
         evt_i.fbit_strobe && evt_i.fbit_err};
      set_v[IDX_INFO_TWO] = {alarm_fall[POS_SYNC_LOSS], alarm_fall[POS_CARRIER_LOSS],
         evt_i.tx_store_full, evt_i.tx_store_empty, evt_i.tx_slip,
         alarm_fall[POS_BLUE], evt_i.rx_density, evt_i.tx_density};
      set_v[IDX_INFO_THREE] = evt_i.info_three_event;
      for (int r = 0; r < NUM_REGS; r++) begin
         clr_v[r] = (host_i.rd && hit && idx == 3'(r)) ? armed[r] : 8'h00;
      end
   end

   // ----------------------------------------
   // Latches, readable copies and write masks
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int r = 0; r < NUM_REGS; r++) begin
            latch[r] <= 8'h00;
         end
      end else begin
         // A set in the same cycle as a read-clear wins.
         for (int r = 0; r < NUM_REGS; r++) begin
            latch[r] <= set_v[r] | (latch[r] & ~clr_v[r]);
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int r = 0; r < NUM_REGS; r++) begin
            copy[r] <= 8'h00;
            armed[r] <= MASK_RESET;
         end
      end else if (host_i.wr && hit) begin
         // The host is expected to read right after this write and to write back.
         copy[idx] <= (host_i.data & latch[idx]) | (~host_i.data & copy[idx]);
         armed[idx] <= host_i.data;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_mask_one <= MASK_RESET;
         irq_mask_two <= MASK_RESET;
      end else if (host_i.wr) begin
         if (host_i.addr == ADDR_IRQ_MASK_ONE) begin
            irq_mask_one <= host_i.data;
         end
         if (host_i.addr == ADDR_IRQ_MASK_TWO) begin
            irq_mask_two <= host_i.data;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= READ_UNMAPPED;
      end else if (host_i.rd) begin
         if (hit) begin
            rdata_o <= copy[idx];
         end else if (host_i.addr == ADDR_IRQ_MASK_ONE) begin
            rdata_o <= irq_mask_one;
         end else if (host_i.addr == ADDR_IRQ_MASK_TWO) begin
            rdata_o <= irq_mask_two;
         end else begin
            rdata_o <= READ_UNMAPPED;
         end
      end
   end

   // ----------------------------------------
   // Interrupt
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         alarm_pend <= 4'h0;
      end else begin
         alarm_pend <= alarm_chg |
            (alarm_pend & ~clr_v[IDX_STAT_ONE][ALARM_BITS-1:0]);
      end
   end

   // Information registers never reach the interrupt; live alarm levels do not either.
   assign any_src = |(latch[IDX_STAT_ONE][7:ALARM_BITS] & irq_mask_one[7:ALARM_BITS]) |
      |(alarm_pend & irq_mask_one[ALARM_BITS-1:0]) |
      |(latch[IDX_STAT_TWO] & irq_mask_two) | fdl_irq_i;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_n_o <= 1'b1;
      end else begin
         irq_n_o <= !any_src;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_SET_LATCHES: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      set_v[IDX_INFO_ONE] != 8'h00 |=> (latch[IDX_INFO_ONE] & $past(set_v[IDX_INFO_ONE]))
         == $past(set_v[IDX_INFO_ONE]))
      else $error("Info register one lost a set event.");

   AST_READ_CLEARS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      host_i.rd && host_i.addr == ADDR_INFO_TWO && set_v[IDX_INFO_TWO] == 8'h00
      |=> (latch[IDX_INFO_TWO] & $past(armed[IDX_INFO_TWO])) == 8'h00)
      else $error("Read did not clear armed bits.");

   AST_ALARM_STAYS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      evt_i.alarm_level[POS_SYNC_LOSS] |=> latch[IDX_STAT_ONE][POS_SYNC_LOSS])
      else $error("Live alarm bit was cleared.");

   AST_MASK_COPY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      host_i.wr && host_i.addr == ADDR_STATUS_TWO |=> copy[IDX_STAT_TWO] ==
         (($past(host_i.data) & $past(latch[IDX_STAT_TWO])) |
          (~$past(host_i.data) & $past(copy[IDX_STAT_TWO]))))
      else $error("Mask write produced a wrong readable copy.");

   AST_ALARM_IRQ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      alarm_chg[POS_CARRIER_LOSS] && irq_mask_one[POS_CARRIER_LOSS] &&
      !(host_i.wr && host_i.addr == ADDR_IRQ_MASK_ONE) ##1 1'b1 |=> !irq_n_o)
      else $error("Alarm change did not pull the interrupt low.");

   AST_ALARM_RELEASE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      host_i.rd && host_i.addr == ADDR_STATUS_ONE && alarm_chg == 4'h0
      |=> (alarm_pend & $past(armed[IDX_STAT_ONE][ALARM_BITS-1:0])) == 4'h0)
      else $error("Alarm interrupt not released by read.");

   AST_EVENT_IRQ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (latch[IDX_STAT_TWO] & irq_mask_two) != 8'h00 |=> !irq_n_o)
      else $error("Unmasked event did not assert the interrupt.");

   AST_IRQ_SOURCES: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !irq_n_o |-> $past(any_src))
      else $error("Interrupt asserted with no unmasked source.");

   AST_ZERO16: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      evt_i.rx_bit_valid && !evt_i.rx_bit && zero_cnt == ZERO_LONG - 5'h01
      |=> latch[IDX_INFO_ONE][POS_SIXTEEN_ZERO])
      else $error("Sixteen zero string not flagged.");

   AST_SEVERE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      evt_i.fbit_strobe && evt_i.fbit_err && fbit_hist[0] |=> latch[IDX_INFO_ONE][POS_SEVERE])
      else $error("Two errored framing bits not flagged.");

   AST_CARRIER_BACK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      alarm_q[POS_CARRIER_LOSS] && !evt_i.alarm_level[POS_CARRIER_LOSS]
      |=> latch[IDX_INFO_TWO][POS_CARRIER_RESTORED])
      else $error("Carrier restore not flagged.");

   AST_FBIT_ERR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      evt_i.fbit_strobe && evt_i.fbit_err |=> latch[IDX_INFO_ONE][POS_FBIT_ERR])
      else $error("Framing bit error not flagged.");
endmodule

// [testbench/host_model.sv]
// Purpose: Behavioural host on the parallel control port of the status bank.
// Assumes: One-cycle wr/rd strobes launched just after a rising edge.
// Notes: Tasks are called hierarchically by the testbench.
module host_model
   import status_bank_pkg::*;
(
   // Clock
   input wire logic core_clk_i,
   // Control port
   output status_bank_pkg::host_req_s host_o,
   input wire logic [7:0] rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   initial host_o = '0;
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge core_clk_i);
      host_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, data: data};
      @(posedge core_clk_i);
      host_o <= '0;
   endtask
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge core_clk_i);
      host_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, data: 8'h00};
      @(posedge core_clk_i);
      host_o <= '0;
      @(posedge core_clk_i);
      data = rdata_i;
   endtask
   // The write-back refreshes the copy of each bit just read and leaves only those bits armed.
   task automatic poll(input logic [7:0] addr, input logic [7:0] mask, output logic [7:0] got);
      @(posedge core_clk_i);
      host_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, data: mask};
      @(posedge core_clk_i);
      host_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, data: 8'h00};
      @(posedge core_clk_i);
      host_o <= '0;
      @(posedge core_clk_i);
      got = rdata_i;
      host_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, data: got & mask};
      @(posedge core_clk_i);
      host_o <= '0;
   endtask
endmodule

// [testbench/latched_status_irq_bank_tb.sv]
// Purpose: Self-checking bench for the latched status and interrupt bank.
// Assumes: Host model drives the control port; bench drives framer events.
// Notes: Table rows cover single event flags; hand tests cover the rest.
module latched_status_irq_bank_tb;
   import status_bank_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0] addr;
      logic [7:0] exp;
      framer_evt_s ev;
   } row_s;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic fdl_irq = 1'b0;
   framer_evt_s evt = '0;
   host_req_s host;
   logic [7:0] rdata;
   logic irq_n;
   logic [7:0] got;
   int fails = 0;
   int num_checks = 0;
   row_s rows[12];
   always #4 core_clk = ~core_clk;
   host_model host_u (.core_clk_i(core_clk), .host_o(host), .rdata_i(rdata));
   latched_status_irq_bank dut_u (.core_clk_i(core_clk), .rst_n_i(rst_n), .host_i(host),
      .rdata_o(rdata), .evt_i(evt), .fdl_irq_i(fdl_irq), .irq_n_o(irq_n));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic report_and_stop;
      if (fails == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic pulse(input framer_evt_s ev);
      @(posedge core_clk);
      evt <= ev;
      @(posedge core_clk);
      evt <= '0;
   endtask
   // Sampled on the falling edge so the registered output has settled.
   task automatic expect_irq(input logic e);
      int k;
      k = 0;
      while (irq_n !== e && k < 6) begin
         @(negedge core_clk);
         k++;
      end
      chk({7'h00, irq_n}, {7'h00, e});
   endtask
   task automatic send_bits(input int n, input logic v);
      repeat (n) begin
         @(posedge core_clk);
         evt.rx_bit_valid <= 1'b1;
         evt.rx_bit <= v;
      end
      @(posedge core_clk);
      evt <= '0;
   endtask
   task automatic frame_bits(input logic [11:0] pat, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge core_clk);
         evt.fbit_strobe <= 1'b1;
         evt.fbit_err <= pat[i];
      end
      @(posedge core_clk);
      evt <= '0;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rows = '{'{ADDR_INFO_ONE, 8'h80, '{align_chg: 1'b1, default: '0}},
         '{ADDR_STATUS_ONE, 8'h80, '{stat_one_event: 4'h8, default: '0}},
         '{ADDR_INFO_THREE, 8'h08, '{info_three_event: 8'h08, default: '0}},
         '{ADDR_INFO_ONE, 8'h10, '{rx_store_full: 1'b1, default: '0}},
         '{ADDR_INFO_ONE, 8'h08, '{rx_store_empty: 1'b1, default: '0}},
         '{ADDR_INFO_ONE, 8'h02, '{b8zs_seen: 1'b1, default: '0}},
         '{ADDR_INFO_ONE, 8'h01, '{fbit_strobe: 1'b1, fbit_err: 1'b1, default: '0}},
         '{ADDR_INFO_TWO, 8'h20, '{tx_store_full: 1'b1, default: '0}},
         '{ADDR_INFO_TWO, 8'h10, '{tx_store_empty: 1'b1, default: '0}},
         '{ADDR_INFO_TWO, 8'h08, '{tx_slip: 1'b1, default: '0}},
         '{ADDR_INFO_TWO, 8'h02, '{rx_density: 1'b1, default: '0}},
         '{ADDR_INFO_TWO, 8'h01, '{tx_density: 1'b1, default: '0}}};
      repeat (5) @(posedge core_clk);
      chk(rdata, 8'h00);
      chk({7'h00, irq_n}, 8'h01);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         pulse(rows[i].ev);
         host_u.poll(rows[i].addr, 8'hFF, got);
         chk(got, rows[i].exp);
         chk({7'h00, irq_n}, 8'h01);
         host_u.poll(rows[i].addr, 8'hFF, got);
         chk(got, 8'h00);
      end
      pulse('{align_chg: 1'b1, rx_store_full: 1'b1, default: '0});
      host_u.poll(ADDR_INFO_ONE, 8'h80, got);
      chk(got, 8'h80);
      // The write-back refreshed bit 7 to its cleared state; a zero mask must hold
      // that copy even though bit 4 is still latched underneath.
      host_u.poll(ADDR_INFO_ONE, 8'h00, got);
      chk(got, 8'h00);
      host_u.poll(ADDR_INFO_ONE, 8'h10, got);
      chk(got, 8'h10);
      send_bits(7, 1'b0);
      send_bits(1, 1'b1);
      host_u.poll(ADDR_INFO_ONE, 8'hFF, got);
      chk(got, 8'h00);
      send_bits(16, 1'b0);
      send_bits(1, 1'b1);
      host_u.poll(ADDR_INFO_ONE, 8'hFF, got);
      chk(got, 8'h60);
      // Leading clean bits flush the error left in the window by the table rows.
      frame_bits(12'h041, 12);
      host_u.poll(ADDR_INFO_ONE, 8'hFF, got);
      chk(got, 8'h01);
      frame_bits(12'h021, 11);
      host_u.poll(ADDR_INFO_ONE, 8'hFF, got);
      chk(got, 8'h05);
      host_u.write_reg(ADDR_IRQ_MASK_ONE, 8'h02);
      @(posedge core_clk);
      evt.alarm_level[POS_CARRIER_LOSS] <= 1'b1;
      expect_irq(1'b0);
      host_u.poll(ADDR_STATUS_ONE, 8'h02, got);
      chk(got, 8'h02);
      expect_irq(1'b1);
      host_u.poll(ADDR_STATUS_ONE, 8'h02, got);
      chk(got, 8'h02);
      chk({7'h00, irq_n}, 8'h01);
      @(posedge core_clk);
      evt.alarm_level[POS_CARRIER_LOSS] <= 1'b0;
      expect_irq(1'b0);
      host_u.poll(ADDR_STATUS_ONE, 8'h02, got);
      chk(got, 8'h02);
      expect_irq(1'b1);
      host_u.poll(ADDR_INFO_TWO, 8'h40, got);
      chk(got, 8'h40);
      host_u.write_reg(ADDR_IRQ_MASK_TWO, 8'h01);
      host_u.read_reg(ADDR_IRQ_MASK_TWO, got);
      chk(got, 8'h01);
      pulse('{stat_two_event: 8'h02, default: '0});
      repeat (4) @(negedge core_clk);
      chk({7'h00, irq_n}, 8'h01);
      pulse('{stat_two_event: 8'h01, default: '0});
      expect_irq(1'b0);
      host_u.poll(ADDR_STATUS_TWO, 8'h01, got);
      chk(got, 8'h01);
      expect_irq(1'b1);
      @(posedge core_clk);
      fdl_irq <= 1'b1;
      expect_irq(1'b0);
      @(posedge core_clk);
      fdl_irq <= 1'b0;
      expect_irq(1'b1);
      host_u.write_reg(ADDR_IRQ_MASK_ONE, 8'h10);
      pulse('{stat_one_event: 4'h1, default: '0});
      expect_irq(1'b0);
      host_u.poll(ADDR_STATUS_ONE, 8'h10, got);
      chk(got, 8'h10);
      expect_irq(1'b1);
      host_u.read_reg(8'h3F, got);
      chk(got, 8'h00);
      report_and_stop();
   end
   initial begin
      #20000;
      fails++;
      report_and_stop();
   end
endmodule
